// ### hw/ulpi_phy_defs.vh
// Constants for the transceiver-side ULPI bus logic
`ifndef ULPI_PHY_DEFS_VH
`define ULPI_PHY_DEFS_VH
// Clock figures
`define SYS_CLOCK_MHZ      125
`define IFC_CLOCK_MHZ      60
// Transmit command field positions
`define TXCMD_CODE_HI      7
`define TXCMD_CODE_LO      6
`define TXCMD_ADDR_HI      5
`define TXCMD_ADDR_LO      0
// Transmit command codes in bits 7:6
`define CMD_SPECIAL        2'h0
`define CMD_TRANSMIT       2'h1
`define CMD_REG_WRITE      2'h2
`define CMD_REG_READ       2'h3
// Reset values
`define IDLE_BYTE          8'h00
`define RXCMD_RESET        8'h00
// Bus operating modes
`define MODE_SYNC          2'h0
`define MODE_LOW_POWER     2'h1
`define MODE_SERIAL6       2'h2
`define MODE_SERIAL3       2'h3
`endif

// ### hw/ulpi_sync2.v
// Two-flip-flop synchroniser for a group of levels
`default_nettype none
module ulpi_sync2 #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             clock,
   input  wire             rst,
   // Levels
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;

   always @(posedge clock) begin
      if (rst) begin
         stage1   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // ulpi_sync2
`default_nettype wire

// ### hw/ulpi_phy_side.v
// Transceiver-side ULPI bus protocol engine
//
// Overview of operation
// R1: Twelve-signal bus: clock, eight data, dir, nxt, stp
// R2: Drive 60 MHz interface clock when reference present
// R3: Sync mode timed by interface clock; else asynchronous
// R4: Interface clock may stop in low-power, serial
// R5: Link holds data low when idle
// R6: Non-zero transmit command starts transfer; zero idle
// R7: One turnaround cycle whenever dir changes; the code gives none on entry to or exit from low-power and serial modes
// R8: Dir low by default in synchronous mode
// R9: Raise dir only with data for link
// R10: Dir and nxt high: decoded USB data
// R11: Dir high, nxt low: status byte
// R12: Register-read data replaces status byte, nxt low
// R13: Dir held high in low-power and serial modes
// R14: Fixed-direction data lines in low-power, serial modes
// R15: Link asserts stp one cycle after last byte
// R16: Dir low, nxt requests following byte next cycle
// R17: Link holds stp high to leave low-power
// R18: Launch and sample on interface clock rising edge
`default_nettype none
`include "ulpi_phy_defs.vh"
module ulpi_phy_side #(
   parameter CLK_ACC_W = 8
) (
   // Clock and reset
   input  wire       clock,
   input  wire       rst,
   // Reference clock presence and interface clock output
   input  wire       reference_clock_input,
   output reg        ifc_clock,
   // ULPI data bus, three signals per line [R1]
   input  wire [7:0] data_in,
   output reg  [7:0] data_out,
   output reg  [7:0] data_oe,
   // ULPI control
   output reg        dir,
   output reg        nxt,
   input  wire       stp,
   // Receive side from the USB core
   input  wire       rx_valid,
   input  wire [7:0] rx_byte,
   input  wire       rx_active,
   input  wire [7:0] rx_status,
   output reg        rx_taken,
   // Transmit side toward the USB core
   output reg        tx_valid,
   output reg  [7:0] tx_byte,
   output reg        tx_last,
   input  wire       tx_ready,
   // Register access toward the register file
   output reg        reg_wr,
   output reg        reg_rd,
   output reg  [5:0] reg_addr,
   output reg  [7:0] reg_wdata,
   input  wire [7:0] reg_rdata,
   // Mode control
   input  wire [1:0] mode_request,
   input  wire [7:0] mode_pins,
   input  wire [7:0] mode_oe,
   output reg  [1:0] mode,
   output reg        wake
);
   // ==========================================================
   // Input synchronisers for pins from outside the clock domain
   // ==========================================================
   wire [7:0] data_s;
   wire [1:0] ctl_s;
   wire       stp_s;
   wire       ref_s;

   ulpi_sync2 #(.WIDTH(8)) u_sync_data (
      .clock    (clock),
      .rst      (rst),
      .async_in (data_in),
      .sync_out (data_s)
   );
   ulpi_sync2 #(.WIDTH(2)) u_sync_ctl (
      .clock    (clock),
      .rst      (rst),
      .async_in ({stp, reference_clock_input}),
      .sync_out (ctl_s)
   );
   assign stp_s = ctl_s[1];
   assign ref_s = ctl_s[0];

   // ==========================================================
   // Interface clock generation by phase accumulation
   // ==========================================================
   localparam integer ACC_STEP_FULL = (2 * `IFC_CLOCK_MHZ * (1 << CLK_ACC_W)) / `SYS_CLOCK_MHZ;
   localparam [CLK_ACC_W-1:0] ACC_STEP = ACC_STEP_FULL[CLK_ACC_W-1:0];
   reg [CLK_ACC_W-1:0] clk_acc;
   reg [CLK_ACC_W:0]   acc_sum;
   wire sync_mode = (mode == `MODE_SYNC);

   always @* begin
      acc_sum = {1'b0, clk_acc} + {1'b0, ACC_STEP};
   end

   always @(posedge clock) begin
      if (rst) begin
         clk_acc   <= {CLK_ACC_W{1'b0}};
         ifc_clock <= 1'b0;
      end else if (ref_s && sync_mode) begin // [R2]
         clk_acc <= acc_sum[CLK_ACC_W-1:0];
         if (acc_sum[CLK_ACC_W])
            ifc_clock <= ~ifc_clock;
      end else begin
         ifc_clock <= 1'b0; // [R4]
      end
   end

   // Sync-mode protocol steps on the rising edge of the interface clock
   reg  ifc_prev;
   wire tick = ifc_clock & ~ifc_prev; // [R18] [R3]

   always @(posedge clock) begin
      if (rst)
         ifc_prev <= 1'b0;
      else
         ifc_prev <= ifc_clock;
   end

   // ==========================================================
   // Bus state machine
   // ==========================================================
   localparam [2:0] S_IDLE   = 3'h0;
   localparam [2:0] S_TX     = 3'h1;
   localparam [2:0] S_REGW   = 3'h2;
   localparam [2:0] S_TA_UP  = 3'h3;
   localparam [2:0] S_OUT    = 3'h4;
   localparam [2:0] S_TA_DN  = 3'h5;
   localparam [2:0] S_ASYNC  = 3'h6;
   localparam [2:0] S_REGD   = 3'h7;

   reg [2:0] state;
   reg       rd_pending;
   reg       tx_armed;
   reg [7:0] last_status;
   wire [1:0] cmd_code = data_s[`TXCMD_CODE_HI:`TXCMD_CODE_LO];
   wire       rx_want  = rx_active | rx_valid | (rx_status != last_status);

   always @(posedge clock) begin
      if (rst) begin
         state       <= S_IDLE;
         dir         <= 1'b0;
         nxt         <= 1'b0;
         data_out    <= `IDLE_BYTE;
         data_oe     <= 8'h00;
         rx_taken    <= 1'b0;
         tx_valid    <= 1'b0;
         tx_byte     <= `IDLE_BYTE;
         tx_last     <= 1'b0;
         reg_wr      <= 1'b0;
         reg_rd      <= 1'b0;
         reg_addr    <= 6'h00;
         reg_wdata   <= 8'h00;
         rd_pending  <= 1'b0;
         tx_armed    <= 1'b0;
         last_status <= `RXCMD_RESET;
         mode        <= `MODE_SYNC;
         wake        <= 1'b0;
      end else begin
         rx_taken <= 1'b0;
         reg_wr   <= 1'b0;
         reg_rd   <= 1'b0;
         tx_valid <= 1'b0;
         tx_last  <= 1'b0;
         wake     <= 1'b0;
         case (state)
            S_ASYNC: begin
               dir      <= 1'b1; // [R13]
               nxt      <= 1'b0;
               data_out <= mode_pins; // [R14]
               data_oe  <= mode_oe;
               if (stp_s) begin // [R17]
                  wake    <= 1'b1;
                  mode    <= `MODE_SYNC;
                  data_oe <= 8'h00;
                  state   <= S_TA_DN;
               end
            end
            default: begin
               if (tick) begin
                  case (state)
                     S_IDLE: begin
                        dir     <= 1'b0; // [R8]
                        tx_armed <= 1'b0;
                        nxt     <= 1'b0;
                        data_oe <= 8'h00;
                        if (mode_request != `MODE_SYNC) begin
                           mode  <= mode_request;
                           dir   <= 1'b1; // [R13]
                           state <= S_ASYNC;
                        end else if (data_s != `IDLE_BYTE) begin // [R6]
                           reg_addr <= data_s[`TXCMD_ADDR_HI:`TXCMD_ADDR_LO];
                           nxt      <= 1'b1; // [R16]
                           case (cmd_code)
                              `CMD_REG_READ: begin
                                 reg_rd     <= 1'b1;
                                 rd_pending <= 1'b1;
                                 nxt        <= 1'b1;
                                 dir        <= 1'b0;
                                 state      <= S_TA_UP;
                              end
                              `CMD_REG_WRITE: state <= S_REGW;
                              default:        state <= S_TX;
                           endcase
                        end else if (rx_want) begin
                           dir   <= 1'b1; // [R9] [R7]
                           state <= S_TA_UP;
                        end
                     end
                     S_TX: begin
                        // First nxt seen here took the command byte itself
                        nxt      <= tx_ready; // [R16]
                        tx_armed <= 1'b1;
                        if (stp_s) begin // [R15]
                           nxt     <= 1'b0;
                           tx_last <= 1'b1;
                           state   <= S_IDLE;
                        end else if (nxt && tx_armed) begin
                           tx_valid <= 1'b1;
                           tx_byte  <= data_s;
                        end
                     end
                     S_REGW: begin
                        // Command byte taken; ask for the data byte
                        nxt   <= 1'b1; // [R16]
                        state <= S_REGD;
                     end
                     S_REGD: begin
                        if (nxt) begin
                           reg_wdata <= data_s;
                           reg_wr    <= 1'b1;
                           nxt       <= 1'b0;
                        end else if (stp_s) begin // [R15]
                           state <= S_IDLE;
                        end
                     end
                     S_TA_UP: begin
                        nxt <= 1'b0;
                        if (!dir) begin
                           // Read: dir rises first, bus stays released one cycle
                           dir <= 1'b1; // [R7]
                        end else begin
                           data_oe <= 8'hFF;
                           state   <= S_OUT;
                           if (rd_pending) begin
                              data_out   <= reg_rdata; // [R12]
                              rd_pending <= 1'b0;
                           end else begin
                              data_out    <= rx_status; // [R11]
                              last_status <= rx_status;
                           end
                        end
                     end
                     S_OUT: begin
                        if (rx_valid) begin
                           data_out <= rx_byte; // [R10]
                           nxt      <= 1'b1;
                           rx_taken <= 1'b1;
                        end else if (rx_active || rx_status != last_status) begin
                           data_out    <= rx_status; // [R11]
                           last_status <= rx_status;
                           nxt         <= 1'b0;
                        end else begin
                           dir     <= 1'b0; // [R7]
                           nxt     <= 1'b0;
                           data_oe <= 8'h00;
                           state   <= S_TA_DN;
                        end
                     end
                     S_TA_DN: begin
                        // Turnaround after dir falls; after wake, dir is still high here and falls on this tick; bus ignored
                        dir     <= 1'b0;
                        data_oe <= 8'h00;
                        state   <= S_IDLE;
                     end
                     default: state <= S_IDLE;
                  endcase
               end
            end
         endcase
      end
   end
endmodule // ulpi_phy_side
`default_nettype wire

// ### dv/ulpi_phy_side_assertions.sv
// Checker for the transceiver-side ULPI bus engine
`default_nettype none
module ulpi_phy_side_checker (
   // Watched ports
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       reference_clock_input,
   input wire logic       ifc_clock,
   input wire logic [7:0] data_oe,
   input wire logic       dir,
   input wire logic       nxt,
   input wire logic       rx_taken,
   input wire logic       reg_rd,
   input wire logic [1:0] mode,
   input wire logic       wake
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_oe_dir: assert property (data_oe != 8'h00 |-> dir)
      else $error("bus driven with dir low");
   a_turn_rise: assert property ($rose(dir) && mode == 2'h0 |-> data_oe == 8'h00)
      else $error("bus driven in turnaround");
   a_turn_fall: assert property ($fell(dir) |-> data_oe == 8'h00)
      else $error("bus held past dir fall");
   a_rx_data: assert property (rx_taken |-> dir && nxt)
      else $error("data byte without dir and nxt");
   a_read_back: assert property (reg_rd |-> !dir ##[1:8] (dir && !nxt))
      else $error("read data not returned");
   a_lp_dir: assert property (mode != 2'h0 |-> dir)
      else $error("dir low outside sync mode");
   a_lp_clock: assert property ((mode != 2'h0)[*2] |-> !ifc_clock)
      else $error("clock runs outside sync mode");
   a_ref_clock: assert property ((!reference_clock_input)[*5] |=> !ifc_clock)
      else $error("clock without reference");
   a_clock_runs: assert property (
      (reference_clock_input && mode == 2'h0)[*8] |-> ##[0:2] $changed(ifc_clock))
      else $error("clock stalled");
   a_wake_sync: assert property (wake |-> ##[0:2] mode == 2'h0)
      else $error("wake without sync mode");
endmodule // ulpi_phy_side_checker
bind ulpi_phy_side ulpi_phy_side_checker chk (.clock(clock), .rst(rst),
   .reference_clock_input(reference_clock_input), .ifc_clock(ifc_clock),
   .data_oe(data_oe), .dir(dir), .nxt(nxt), .rx_taken(rx_taken), .reg_rd(reg_rd),
   .mode(mode), .wake(wake));
`default_nettype wire

// ### dv/ulpi_link_model.sv
// Behavioural link controller on the far side of the ULPI bus
`default_nettype none
module ulpi_link_model (
   // From the transceiver
   input  wire logic       ifc_clock,
   input  wire logic       dir,
   input  wire logic       nxt,
   input  wire logic [7:0] data_out,
   input  wire logic [7:0] data_oe,
   // To the transceiver
   output wire logic [7:0] data_in,
   output wire logic       stp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] link_byte = 8'h00;
   logic [7:0] last_byte = 8'h00;
   logic       stp_pulse = 1'b0;
   logic       stp_hold  = 1'b0;
   logic       prev_dir  = 1'b0;
   logic [7:0] rx_cmd    = 8'h00;
   logic [7:0] rx_data   = 8'h00;
   int         n_cmd     = 0;
   // Released lines show the inverse of the link's last byte while dir is high, else the link's current byte
   assign data_in = (data_oe & data_out) | (~data_oe & (dir ? ~last_byte : link_byte));
   assign stp = stp_pulse | stp_hold;
   // The cycle after each dir change is turnaround and is skipped
   always @(posedge ifc_clock) begin
      prev_dir <= dir;
      if (dir && prev_dir && nxt) begin
         rx_data <= data_in;
      end else if (dir && prev_dir) begin
         rx_cmd <= data_in;
         n_cmd  <= n_cmd + 1;
      end
   end
   // Holds a byte until nxt is sampled high
   task automatic put(input logic [7:0] b, inout bit ok);
      int n;
      link_byte = b;
      last_byte = b;
      n = 0;
      do begin
         @(posedge ifc_clock);
         n++;
      end while (nxt !== 1'b1 && n < 64);
      ok = ok && nxt === 1'b1;
      #1;
   endtask
   task automatic reg_write(input logic [5:0] a, input logic [7:0] v, output bit ok);
      ok = 1;
      @(posedge ifc_clock);
      #1;
      put({2'h2, a}, ok);
      put(v, ok);
      link_byte = 8'h00;
      stp_pulse = 1'b1;
      @(posedge ifc_clock);
      #1;
      stp_pulse = 1'b0;
   endtask
   task automatic reg_read(input logic [5:0] a, output logic [7:0] v, output bit ok);
      int n, c;
      ok = 1;
      @(posedge ifc_clock);
      #1;
      put({2'h3, a}, ok);
      link_byte = 8'h00;
      c = n_cmd;
      for (n = 0; n < 64 && n_cmd == c; n++) begin
         @(posedge ifc_clock);
         #1;
      end
      ok = ok && n_cmd != c;
      v = rx_cmd;
   endtask
   task automatic tx_packet(input logic [7:0] c, input logic [7:0] p0, input logic [7:0] p1,
                            output bit ok);
      ok = 1;
      @(posedge ifc_clock);
      #1;
      put(c, ok);
      put(p0, ok);
      put(p1, ok);
      link_byte = 8'h00;
      stp_pulse = 1'b1;
      @(posedge ifc_clock);
      #1;
      stp_pulse = 1'b0;
   endtask
endmodule // ulpi_link_model
`default_nettype wire

// ### dv/tb_ulpi_phy_side.sv
// Testbench for the transceiver-side ULPI bus engine
`default_nettype none
module tb_ulpi_phy_side;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock = 0, rst = 1, refc = 1, rx_valid = 0, rx_active = 0, tx_ready = 1;
   logic       ifc_clock, dir, nxt, stp, rx_taken, reg_wr, reg_rd, wake, wr_seen = 0;
   logic [7:0] data_in, data_out, data_oe, rx_byte = 0, rx_status = 0, reg_rdata = 0;
   logic [7:0] mode_pins = 0, mode_oe = 0, reg_wdata, wd, got;
   logic [5:0] reg_addr, wa, ra;
   logic       tx_valid, tx_last;
   logic [7:0] tx_byte, tx_b0, tx_b1;
   int         n_tx = 0, n_last = 0;
   logic [1:0] mode_request = 0, mode;
   int         n_errors = 0, samples_checked = 0, n_ifc = 0, n0;
   bit         ok;
   always #4 clock = ~clock;
   always @(posedge ifc_clock) n_ifc++;
   always @(posedge clock) begin
      if (reg_wr) begin
         wa <= reg_addr;
         wd <= reg_wdata;
         wr_seen <= 1;
      end
      if (reg_rd) ra <= reg_addr;
      if (tx_valid) begin
         tx_b0 <= tx_b1;
         tx_b1 <= tx_byte;
         n_tx <= n_tx + 1;
      end
      if (tx_last) n_last <= n_last + 1;
   end
   ulpi_phy_side dut (.clock(clock), .rst(rst), .reference_clock_input(refc),
      .ifc_clock(ifc_clock), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .dir(dir), .nxt(nxt), .stp(stp), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_active(rx_active), .rx_status(rx_status), .rx_taken(rx_taken),
      .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready),
      .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .mode_request(mode_request), .mode_pins(mode_pins), .mode_oe(mode_oe),
      .mode(mode), .wake(wake));
   ulpi_link_model link (.ifc_clock(ifc_clock), .dir(dir), .nxt(nxt),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .stp(stp));
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   function automatic logic [7:0] pick(int s);
      case (s)
         0: return {7'h00, dir};
         1: return {6'h00, mode};
         2: return {7'h00, wake};
         3: return {7'h00, rx_taken};
         default: return {7'h00, wr_seen};
      endcase
   endfunction
   task automatic await(input int s, input logic [7:0] v);
      int n;
      for (n = 0; n < 400 && pick(s) !== v; n++) begin
         @(posedge clock);
         #1;
      end
      check(pick(s), v);
      if (n == 400) final_report();
   endtask
   task automatic t_idle_clock;
      n0 = n_ifc;
      repeat (120) @(posedge clock);
      #1;
      check(8'(n_ifc - n0 >= 55 && n_ifc - n0 <= 60), 8'h01);
      check({6'h00, dir, nxt}, 8'h00);
      check(data_oe, 8'h00);
      refc = 0;
      repeat (10) @(posedge clock);
      n0 = n_ifc;
      repeat (40) @(posedge clock);
      check(8'(n_ifc - n0), 8'h00);
      #1;
      refc = 1;
      repeat (10) @(posedge clock);
      #1;
      $display("idle and clock done");
   endtask
   task automatic t_registers;
      reg_rdata = 8'hA5;
      link.reg_read(6'h15, got, ok);
      check({7'h00, ok}, 8'h01);
      if (!ok) final_report();
      check(got, 8'hA5);
      check({2'h0, ra}, 8'h15);
      await(0, 8'h00);
      link.reg_write(6'h2A, 8'h3C, ok);
      check({7'h00, ok}, 8'h01);
      await(4, 8'h01);
      check({2'h0, wa}, 8'h2A);
      check(wd, 8'h3C);
      $display("register access done");
   endtask
   task automatic t_transmit;
      int k, t0, l0;
      for (k = 0; k < 2; k++) begin
         t0 = n_tx;
         l0 = n_last;
         link.tx_packet(k ? 8'h0F : 8'h41, 8'h96, 8'h69 ^ 8'(k), ok);
         check({7'h00, ok}, 8'h01);
         repeat (8) @(posedge clock);
         #1;
         check(8'(n_tx - t0), 8'h02);
         check(8'(n_last - l0), 8'h01);
         check(tx_b0, 8'h96);
         check(tx_b1, 8'h69 ^ 8'(k));
      end
      $display("transmit done");
   endtask
   task automatic t_receive;
      @(posedge clock);
      #1;
      rx_status = 8'h4E;
      rx_active = 1;
      rx_byte = 8'h5A;
      rx_valid = 1;
      await(3, 8'h01);
      rx_valid = 0;
      rx_active = 0;
      await(0, 8'h00);
      check(link.rx_data, 8'h5A);
      check(link.rx_cmd, 8'h4E);
      $display("receive done");
   endtask
   task automatic t_low_power;
      for (int m = 1; m < 4; m++) begin
         mode_request = 2'(m);
         mode_pins = 8'hC3;
         mode_oe = 8'h0F;
         await(1, 8'(m));
         repeat (4) @(posedge clock);
         #1;
         check({7'h00, dir}, 8'h01);
         check(data_oe, 8'h0F);
         check(data_out & 8'h0F, 8'h03);
         check({7'h00, ifc_clock}, 8'h00);
         link.stp_hold = 1;
         mode_request = 0;
         await(2, 8'h01);
         link.stp_hold = 0;
         await(0, 8'h00);
         check({6'h00, mode}, 8'h00);
      end
      $display("low power done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      #1;
      rst = 0;
      repeat (20) @(posedge clock);
      t_idle_clock();
      t_registers();
      t_transmit();
      t_receive();
      t_low_power();
      final_report();
   end
endmodule // tb_ulpi_phy_side
`default_nettype wire
